// ### hdl/adcdm_top.sv
// Purpose: ADC back end: decimation, word hand-off, digital mic input, dc measurement
// Assumes: Wishbone classic slave; mic data and pins are asynchronous to clk_sys_in
// Notes:   Modulator clock made here by dividing clk_sys_in
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcdm_regs.svh"

// Overview of operation
// - Pass 32-bit words to the serial interface once per sample period.
// - Each sample period delivers a left word and a right word.
// - Serial interface rounds each word to its configured word length.
// - Same mono sample goes into both left and right slots.
// - Ratio 32 selects third decimation variant for 192 ksps.
// - Pin function code 1010 drives modulator clock on pin one.
// - Mic bit sampled on every rising modulator clock edge.
// - Config bit 7 enables dc-measurement mode.
// - Result is 24-bit signed 2.22 over three readback registers.
// - Control bit 6 at one latches result into readback registers.
// - Config bit 5 zero selects averaging filter, length code 1 to 20.
// - Config bit 5 one selects a first-order IIR filter.
// - In IIR mode length code sets coefficients, each step halves bandwidth.
// - Control bit 5 resets averaging every 2^R modulator periods.
// - Control bit 5 zero means no interval reset.
// - Decimation variant follows implicitly from the selected processing; the code picks it from the ratio alone.
// - Second variant serves up to 96 kHz at ratio 64.
module adcdm_top (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [9:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        mic_data_in,
  input  wire logic        multipurpose_pin_one_in,
  output logic             multipurpose_pin_one_out,
  output logic             multipurpose_pin_one_oe_out,
  output logic      [31:0] word_left_out,
  output logic      [31:0] word_right_out,
  output logic             word_valid_out
);
  // Reset release through two flops
  logic rst_meta, rst_sync;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Register read decode, shared by the bus mux
  function automatic logic [7:0] adcdm_reg_read(
    input logic [7:0]  idx,
    input logic [7:0]  pin_func,
    input logic [7:0]  osr,
    input logic [7:0]  cfg,
    input logic [7:0]  ctl,
    input logic [23:0] rb,
    input logic [7:0]  ser
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `ADCDM_IDX_PIN_ONE_FUNC:  v = pin_func;
      `ADCDM_IDX_OSR:           v = osr;
      `ADCDM_IDX_DC_CONFIG:     v = cfg;
      `ADCDM_IDX_DC_CONTROL:    v = ctl;
      `ADCDM_IDX_DC_RESULT_HI:  v = rb[23:16];
      `ADCDM_IDX_DC_RESULT_MID: v = rb[15:8];
      `ADCDM_IDX_DC_RESULT_LO:  v = rb[7:0];
      `ADCDM_IDX_SER_CTRL:      v = ser;
      default:                  v = 8'h00;
    endcase
    return v;
  endfunction : adcdm_reg_read

  // Control registers and bus handshake state
  adcdm_pkg::adcdm_wb_state_t wb_state, next_wb_state;
  logic [7:0]  pin_func, next_pin_func;
  logic [7:0]  osr_reg, next_osr_reg;
  logic [7:0]  dc_cfg, next_dc_cfg;
  logic [7:0]  dc_ctl, next_dc_ctl;
  logic [7:0]  ser_ctl, next_ser_ctl;
  logic [31:0] next_wb_dat;
  logic        next_wb_ack;
  logic [7:0]  bus_idx;
  logic [23:0] readback;
  logic        bus_req;

  assign bus_idx = wb_adr_in[9:2];
  assign bus_req = wb_cyc_in && wb_stb_in;

  // Wishbone slave: one wait cycle, ack for one cycle, then a gap
  always_comb begin
    next_wb_state = wb_state;
    next_pin_func = pin_func;
    next_osr_reg  = osr_reg;
    next_dc_cfg   = dc_cfg;
    next_dc_ctl   = dc_ctl;
    next_ser_ctl  = ser_ctl;
    next_wb_dat   = wb_dat_out;
    next_wb_ack   = 1'b0;
    unique case (wb_state)
      adcdm_pkg::ADCDM_WB_IDLE: begin
        if (bus_req) begin
          next_wb_ack   = 1'b1;
          next_wb_state = adcdm_pkg::ADCDM_WB_ACK;
          next_wb_dat   = {24'h000000, adcdm_reg_read(bus_idx, pin_func, osr_reg,
                                                      dc_cfg, dc_ctl, readback, ser_ctl)};
          if (wb_we_in && wb_sel_in[0]) begin
            unique case (bus_idx)
              `ADCDM_IDX_PIN_ONE_FUNC: next_pin_func = wb_dat_in[7:0];
              `ADCDM_IDX_OSR:          next_osr_reg  = wb_dat_in[7:0];
              `ADCDM_IDX_DC_CONFIG:    next_dc_cfg   = wb_dat_in[7:0];
              `ADCDM_IDX_DC_CONTROL:   next_dc_ctl   = wb_dat_in[7:0];
              `ADCDM_IDX_SER_CTRL:     next_ser_ctl  = wb_dat_in[7:0];
              default:                 next_pin_func = pin_func;
            endcase
          end
        end
      end
      adcdm_pkg::ADCDM_WB_ACK: next_wb_state = adcdm_pkg::ADCDM_WB_GAP;
      adcdm_pkg::ADCDM_WB_GAP: begin
        if (!bus_req)
          next_wb_state = adcdm_pkg::ADCDM_WB_IDLE;
      end
      default: next_wb_state = adcdm_pkg::ADCDM_WB_IDLE;
    endcase
  end

  // Register state
  always_ff @(posedge clk_sys_in or negedge rst_sync) begin
    if (!rst_sync) begin
      wb_state   <= adcdm_pkg::ADCDM_WB_IDLE;
      pin_func   <= 8'h00;
      osr_reg    <= `ADCDM_OSR_RESET;
      dc_cfg     <= `ADCDM_CFG_RESET;
      dc_ctl     <= `ADCDM_CTL_RESET;
      ser_ctl    <= `ADCDM_SER_RESET;
      wb_dat_out <= 32'h00000000;
      wb_ack_out <= 1'b0;
    end else begin
      wb_state   <= next_wb_state;
      pin_func   <= next_pin_func;
      osr_reg    <= next_osr_reg;
      dc_cfg     <= next_dc_cfg;
      dc_ctl     <= next_dc_ctl;
      ser_ctl    <= next_ser_ctl;
      wb_dat_out <= next_wb_dat;
      wb_ack_out <= next_wb_ack;
    end
  end

  // Modulator clock divider and mic input synchroniser
  logic [3:0] div_cnt, next_div_cnt;
  logic       mod_clk, next_mod_clk;
  logic       mod_rise, next_mod_rise;
  logic       mic_meta, mic_sync, mic_bit, next_mic_bit;
  logic       pin_drv, next_pin_drv;

  always_comb begin
    next_div_cnt  = div_cnt + 4'h1;
    next_mod_clk  = mod_clk;
    next_mod_rise = 1'b0;
    next_mic_bit  = mic_bit;
    if (div_cnt == 4'(`ADCDM_MOD_HALF_CYC - 1)) begin
      next_div_cnt  = 4'h0;
      next_mod_clk  = !mod_clk;
      next_mod_rise = !mod_clk;
    end
    if (next_mod_rise)
      next_mic_bit = mic_sync;
    next_pin_drv = (pin_func[`ADCDM_PIN_FUNC_MSB:`ADCDM_PIN_FUNC_LSB]
                    == `ADCDM_PIN_FUNC_MODCLK);
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync) begin
    if (!rst_sync) begin
      div_cnt                     <= 4'h0;
      mod_clk                     <= 1'b0;
      mod_rise                    <= 1'b0;
      mic_meta                    <= 1'b0;
      mic_sync                    <= 1'b0;
      mic_bit                     <= 1'b0;
      pin_drv                     <= 1'b0;
      multipurpose_pin_one_out    <= 1'b0;
      multipurpose_pin_one_oe_out <= 1'b0;
    end else begin
      div_cnt                     <= next_div_cnt;
      mod_clk                     <= next_mod_clk;
      mod_rise                    <= next_mod_rise;
      mic_meta                    <= mic_data_in;
      mic_sync                    <= mic_meta;
      mic_bit                     <= next_mic_bit;
      pin_drv                     <= next_pin_drv;
      multipurpose_pin_one_out    <= next_mod_clk && next_pin_drv;
      multipurpose_pin_one_oe_out <= next_pin_drv;
    end
  end

  // Decimation path
  logic [31:0] dec_sample;
  logic        dec_valid;
  adcdm_pkg::adcdm_filt_t filt_sel;

  adcdm_decim u_decim (
    .clk_in           (clk_sys_in),
    .rst_b_in         (rst_sync),
    .bit_valid_in     (mod_rise),
    .bit_in           (mic_bit),
    .osr_in           (osr_reg),
    .sample_out       (dec_sample),
    .sample_valid_out (dec_valid),
    .filt_out         (filt_sel)
  );

  // Word hand-off with rounding to the serial word length
  logic [31:0] rounded, next_left, next_right;
  logic        next_word_valid;
  logic [5:0]  drop_bits;

  always_comb begin
    // Word length code 0..3 gives 16, 20, 24, 32 bits
    unique case (ser_ctl[1:0])
      2'h0:    drop_bits = 6'h10;
      2'h1:    drop_bits = 6'h0C;
      2'h2:    drop_bits = 6'h08;
      default: drop_bits = 6'h00;
    endcase
    // round to word length, saturating at full scale
    if (drop_bits == 6'h00)
      rounded = dec_sample;
    else if (dec_sample[31] == 1'b0 &&
             (dec_sample | ((32'h00000001 << drop_bits) - 32'h00000001)) == 32'h7FFFFFFF)
      rounded = dec_sample & ~((32'h00000001 << drop_bits) - 32'h00000001);
    else
      rounded = (dec_sample + (32'h00000001 << (drop_bits - 6'h01)))
                & ~((32'h00000001 << drop_bits) - 32'h00000001);
    next_left       = word_left_out;
    next_right      = word_right_out;
    next_word_valid = 1'b0;
    if (dec_valid) begin
      next_left       = rounded;
      next_right      = rounded;
      next_word_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync) begin
    if (!rst_sync) begin
      word_left_out  <= 32'h00000000;
      word_right_out <= 32'h00000000;
      word_valid_out <= 1'b0;
    end else begin
      word_left_out  <= next_left;
      word_right_out <= next_right;
      word_valid_out <= next_word_valid;
    end
  end

  // Dc measurement: interval reset and readback latch
  logic [31:0] intv_cnt, next_intv_cnt;
  logic        intv_clear;
  logic [23:0] dc_result, next_readback;
  logic        latch_q, next_latch_q;

  always_comb begin
    next_intv_cnt = intv_cnt;
    intv_clear    = 1'b0;
    if (dc_ctl[`ADCDM_DC_PRST_BIT] && mod_rise) begin
      if (intv_cnt + 32'h1 >= (32'h1 << dc_ctl[4:0])) begin
        next_intv_cnt = 32'h0;
        intv_clear    = 1'b1;
      end else begin
        next_intv_cnt = intv_cnt + 32'h1;
      end
    end else if (!dc_ctl[`ADCDM_DC_PRST_BIT]) begin
      next_intv_cnt = 32'h0;
    end
    // copy on latch rise; hold while set
    next_latch_q  = dc_ctl[`ADCDM_DC_LATCH_BIT];
    next_readback = readback;
    if (dc_ctl[`ADCDM_DC_LATCH_BIT] && !latch_q)
      next_readback = dc_result;
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync) begin
    if (!rst_sync) begin
      intv_cnt <= 32'h0;
      latch_q  <= 1'b0;
      readback <= 24'h000000;
    end else begin
      intv_cnt <= next_intv_cnt;
      latch_q  <= next_latch_q;
      readback <= next_readback;
    end
  end

  adcdm_dcfilt u_dcfilt (
    .clk_in          (clk_sys_in),
    .rst_b_in        (rst_sync),
    .enable_in       (dc_cfg[`ADCDM_DC_EN_BIT]),
    .iir_mode_in     (dc_cfg[`ADCDM_DC_MODE_BIT]),
    .length_in       ((dc_cfg[4:0] > `ADCDM_LEN_MAX) ? `ADCDM_LEN_MAX :
                      ((dc_cfg[4:0] == 5'h00) ? 5'h01 : dc_cfg[4:0])),
    .clear_in        (intv_clear),
    .sample_valid_in (mod_rise),
    .bit_in          (mic_bit),
    .result_out      (dc_result)
  );
endmodule : adcdm_top
`default_nettype wire

// ### hdl/adcdm_regs.svh
// Purpose: Register offsets, field positions and timing counts for the ADC back end
// Assumes: Wishbone byte addresses are four times the register index
// Notes:   Definitions only
`ifndef ADCDM_REGS_SVH
`define ADCDM_REGS_SVH

`define ADCDM_IDX_PIN_ONE_FUNC   8'h33
`define ADCDM_IDX_OSR            8'h34
`define ADCDM_IDX_DC_CONFIG      8'h66
`define ADCDM_IDX_DC_CONTROL     8'h67
`define ADCDM_IDX_DC_RESULT_HI   8'h68
`define ADCDM_IDX_DC_RESULT_MID  8'h69
`define ADCDM_IDX_DC_RESULT_LO   8'h6A
`define ADCDM_IDX_SER_CTRL       8'h6B
`define ADCDM_PIN_FUNC_MSB       5
`define ADCDM_PIN_FUNC_LSB       2
`define ADCDM_PIN_FUNC_MODCLK    4'hA
`define ADCDM_DC_EN_BIT          7
`define ADCDM_DC_MODE_BIT        5
`define ADCDM_DC_LATCH_BIT       6
`define ADCDM_DC_PRST_BIT        5
`define ADCDM_OSR_RESET          8'h40
`define ADCDM_CFG_RESET          8'h01
`define ADCDM_CTL_RESET          8'h00
`define ADCDM_SER_RESET          8'h03
`define ADCDM_LEN_MAX            5'h14
`define ADCDM_OSR_A              8'h80
`define ADCDM_OSR_B              8'h40
`define ADCDM_OSR_C              8'h20
`define ADCDM_SYS_PERIOD_NS      40
`define ADCDM_MOD_PERIOD_NS      320
`define ADCDM_MOD_HALF_CYC       ((`ADCDM_MOD_PERIOD_NS / `ADCDM_SYS_PERIOD_NS) / 2)

`endif

// ### hdl/adcdm_pkg.sv
// Purpose: Types shared by the ADC back end
// Assumes: Nothing beyond the register header
// Notes:   Filter variant follows from the oversampling ratio
package adcdm_pkg;
  typedef enum logic [1:0] {ADCDM_FILT_A, ADCDM_FILT_B, ADCDM_FILT_C} adcdm_filt_t;
  typedef enum logic [1:0] {ADCDM_WB_IDLE, ADCDM_WB_ACK, ADCDM_WB_GAP} adcdm_wb_state_t;
endpackage : adcdm_pkg

// ### hdl/adcdm_decim.sv
// Purpose: Decimator from the modulator bit stream to one sample per sample period
// Assumes: bit_valid_in pulses once per modulator clock rising edge
// Notes:   Integrate-and-dump counter; variant chosen from the ratio
`timescale 1ns/1ps
`default_nettype none
`include "adcdm_regs.svh"
module adcdm_decim (
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               bit_valid_in,
  input  wire logic               bit_in,
  input  wire logic [7:0]         osr_in,
  output logic      [31:0]        sample_out,
  output logic                    sample_valid_out,
  output adcdm_pkg::adcdm_filt_t  filt_out
);
  logic [7:0]  cnt, next_cnt;
  logic [8:0]  acc, next_acc;
  logic [31:0] next_sample;
  logic [9:0]  diff;
  logic        next_valid;
  adcdm_pkg::adcdm_filt_t next_filt;

  // ratio 32 takes C, ratio 64 takes B
  always_comb begin
    next_cnt    = cnt;
    next_acc    = acc;
    next_sample = sample_out;
    next_valid  = 1'b0;
    // Ones minus zeros over the window, two's complement
    diff        = {acc + {8'h00, bit_in}, 1'b0} - {2'b00, osr_in};
    if (osr_in == `ADCDM_OSR_C)
      next_filt = adcdm_pkg::ADCDM_FILT_C;
    else if (osr_in == `ADCDM_OSR_B)
      next_filt = adcdm_pkg::ADCDM_FILT_B;
    else
      next_filt = adcdm_pkg::ADCDM_FILT_A;
    if (bit_valid_in) begin
      if (cnt + 8'h01 >= osr_in) begin
        // Signed count scaled by 2^23; any ratio fits without wrapping the sign
        next_sample = {{22{diff[9]}}, diff} << 23;
        next_valid  = 1'b1;
        next_cnt    = 8'h00;
        next_acc    = 9'h000;
      end else begin
        next_cnt = cnt + 8'h01;
        next_acc = acc + {8'h00, bit_in};
      end
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt              <= 8'h00;
      acc              <= 9'h000;
      sample_out       <= 32'h00000000;
      sample_valid_out <= 1'b0;
      filt_out         <= adcdm_pkg::ADCDM_FILT_A;
    end else begin
      cnt              <= next_cnt;
      acc              <= next_acc;
      sample_out       <= next_sample;
      sample_valid_out <= next_valid;
      filt_out         <= next_filt;
    end
  end
endmodule : adcdm_decim
`default_nettype wire

// ### hdl/adcdm_dcfilt.sv
// Purpose: Dc-measurement filter, averaging (mode A) or first-order IIR (mode B)
// Assumes: Sample strobe once per modulator period
// Notes:   Output is 2.22 signed
`timescale 1ns/1ps
`default_nettype none
module adcdm_dcfilt (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        enable_in,
  input  wire logic        iir_mode_in,
  input  wire logic [4:0]  length_in,
  input  wire logic        clear_in,
  input  wire logic        sample_valid_in,
  input  wire logic        bit_in,
  output logic      [23:0] result_out
);
  logic [44:0] acc, next_acc;
  logic [20:0] cnt, next_cnt;
  logic [23:0] next_result;
  logic [23:0] x;
  logic [24:0] step;

  // Averaging and IIR update
  always_comb begin
    x           = bit_in ? 24'h400000 : 24'hC00000; // +1.0 or -1.0
    // Difference kept at 25 bits so +1 minus -1 cannot wrap
    step        = $signed({x[23], x} - {result_out[23], result_out}) >>> length_in;
    next_acc    = acc;
    next_cnt    = cnt;
    next_result = result_out;
    if (!enable_in || clear_in) begin
      next_acc = 45'h0;
      next_cnt = 21'h0;
    end else if (sample_valid_in) begin
      if (iir_mode_in) begin
        next_result = result_out + step[23:0];
      end else begin
        next_acc = acc + {{21{x[23]}}, x};
        next_cnt = cnt + 21'h1;
        // A count left over from a longer length ends its window at once
        if (next_cnt >= (21'h1 << length_in)) begin
          next_result = 24'($signed(next_acc) >>> length_in);
          next_acc    = 45'h0;
          next_cnt    = 21'h0;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc        <= 45'h0;
      cnt        <= 21'h0;
      result_out <= 24'h000000;
    end else begin
      acc        <= next_acc;
      cnt        <= next_cnt;
      result_out <= next_result;
    end
  end
endmodule : adcdm_dcfilt
`default_nettype wire

// ### tb/adcdm_checker.sv
// Purpose: Port-level assertions for adcdm_top
// Assumes: Register writes land on the ack edge
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "adcdm_regs.svh"
module adcdm_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [9:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        multipurpose_pin_one_out,
  input wire logic        multipurpose_pin_one_oe_out,
  input wire logic [31:0] word_left_out,
  input wire logic [31:0] word_right_out,
  input wire logic        word_valid_out
);
  logic [7:0]  func, next_func, ser, next_ser;
  logic [3:0]  quiet, next_quiet;
  logic [8:0]  gap, next_gap;
  logic [31:0] lmask;
  logic        wr;
  assign wr = wb_ack_out & wb_cyc_in & wb_stb_in & wb_we_in & wb_sel_in[0];
  // Snoop written registers, count quiet cycles and the gap between words
  always_comb begin
    next_func  = func;
    next_ser   = ser;
    next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
    next_gap   = word_valid_out ? 9'h000 : ((gap == 9'h1FF) ? gap : gap + 9'h001);
    if (wr) begin
      next_quiet = 4'h0;
      if (wb_adr_in[9:2] == `ADCDM_IDX_PIN_ONE_FUNC) next_func = wb_dat_in[7:0];
      if (wb_adr_in[9:2] == `ADCDM_IDX_SER_CTRL) next_ser = wb_dat_in[7:0];
    end
    case (ser[1:0])
      2'h0: lmask = 32'h0000FFFF;
      2'h1: lmask = 32'h00000FFF;
      2'h2: lmask = 32'h000000FF;
      default: lmask = 32'h00000000;
    endcase
  end
  // Helper registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      func  <= 8'h00;
      ser   <= `ADCDM_SER_RESET;
      quiet <= 4'h0;
      gap   <= 9'h1FF;
    end else begin
      func  <= next_func;
      ser   <= next_ser;
      quiet <= next_quiet;
      gap   <= next_gap;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_wv_pulse; word_valid_out |=> !word_valid_out; endproperty
  a_wv_pulse: assert property (p_wv_pulse) else $error("word valid too long");
  property p_wv_space; word_valid_out |-> gap >= 9'd255; endproperty
  a_wv_space: assert property (p_wv_space) else $error("words too close");
  property p_lr_eq; word_valid_out |-> word_left_out == word_right_out; endproperty
  a_lr_eq: assert property (p_lr_eq) else $error("left and right differ");
  property p_hold;
    !word_valid_out |-> $stable(word_left_out) && $stable(word_right_out);
  endproperty
  a_hold: assert property (p_hold) else $error("words moved without valid");
  property p_round;
    word_valid_out && quiet == 4'hF |-> (word_left_out & lmask) == 32'h0;
  endproperty
  a_round: assert property (p_round) else $error("word not rounded");
  property p_oe;
    quiet == 4'hF |->
      multipurpose_pin_one_oe_out == (func[5:2] == `ADCDM_PIN_FUNC_MODCLK);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pin_off; !multipurpose_pin_one_oe_out |-> !multipurpose_pin_one_out; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
  property p_pin_per;
    $rose(multipurpose_pin_one_out) |->
      ##8 ($rose(multipurpose_pin_one_out) || !multipurpose_pin_one_oe_out);
  endproperty
  a_pin_per: assert property (p_pin_per) else $error("modulator clock period wrong");
  property p_ack; $rose(wb_stb_in) && wb_cyc_in |=> wb_ack_out ##1 !wb_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_dat_hi; wb_ack_out |-> wb_dat_out[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("read data high bits set");
endmodule : adcdm_checker

bind adcdm_top adcdm_checker u_chk (
  .clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .multipurpose_pin_one_out(multipurpose_pin_one_out),
  .multipurpose_pin_one_oe_out(multipurpose_pin_one_oe_out),
  .word_left_out(word_left_out),
  .word_right_out(word_right_out),
  .word_valid_out(word_valid_out)
);
`default_nettype wire

// ### tb/adcdm_mic_model.sv
// Purpose: Behavioural single-bit digital microphone
// Assumes: Modulator clock comes from pin one
// Notes:   Density sets the share of ones; all ones at 8'hFF
`timescale 1ns/1ps
`default_nettype none
module adcdm_mic_model (
  input  wire logic       mod_clk_in,
  input  wire logic       en_in,
  input  wire logic [7:0] density_in,
  output logic            data_out
);
  logic [8:0] acc;
  initial begin
    acc = 9'h000;
    data_out = 1'b0;
  end
  // steady at rising edge
  // Launch the next bit on the falling edge, half a period ahead
  always @(negedge mod_clk_in) begin
    acc = {1'b0, acc[7:0]} + {1'b0, density_in};
    data_out = acc[8] | (&density_in);
  end
  // Line wanders while the clock stands still
  always #37 if (!en_in) data_out = ~data_out;
endmodule : adcdm_mic_model
`default_nettype wire

// ### tb/tb_adc_decimation_dc_measure.sv
// Purpose: Self-checking bench for adcdm_top
// Assumes: Mic model clocked from pin one
// Notes:   Random register data and mic density from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "adcdm_regs.svh"
module tb_adc_decimation_dc_measure;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic        cyc        = 1'b0;
  logic        stb        = 1'b0;
  logic        we         = 1'b0;
  logic [9:0]  adr        = 10'h000;
  logic [3:0]  sel        = 4'h0;
  logic [31:0] wdat       = 32'h0;
  logic [7:0]  dens       = 8'hFF;
  logic [7:0]  q, v;
  logic [23:0] res;
  logic [7:0]  lctl       = 8'h40;
  int          t;
  int          err_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  wire logic [31:0] rdat, wl, wrt;
  wire logic        ack, mic, pin, oe, wv;
  wire logic        pin_lvl = oe ? pin : 1'b0;
  logic [7:0] ri[5] = '{8'h10, 8'h34, 8'h66, 8'h67, 8'h6B};
  logic [7:0] rv[5] = '{8'h00, 8'h40, 8'h01, 8'h00, 8'h03};
  logic [7:0] ra[3] = '{8'h40, 8'h80, 8'h20};
  adcdm_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .mic_data_in(mic),
    .multipurpose_pin_one_in(pin_lvl), .multipurpose_pin_one_out(pin),
    .multipurpose_pin_one_oe_out(oe), .word_left_out(wl), .word_right_out(wrt),
    .word_valid_out(wv));
  adcdm_mic_model mic_m (.mod_clk_in(pin), .en_in(oe), .density_in(dens), .data_out(mic));
  // Clock and hang guard
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  function automatic logic [31:0] low_mask(input logic [1:0] c);
    return (c == 2'h3) ? 32'h0 : (32'hFFFF >> (4 * c));
  endfunction : low_mask
  function automatic logic [23:0] dc_full(input logic one);
    return one ? 24'h400000 : 24'hC00000;
  endfunction : dc_full
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d, input logic s);
    int n;
    @(posedge clk_sys_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {i, 2'b00};
    sel  <= {3'h0, s};
    wdat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_sys_in); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) chk("ack", 1, 0);
  endtask : wb
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00, 1'b1);
    chk("register", {24'h0, e}, {24'h0, q});
  endtask : rdc
  task automatic pulse();
    t = 0;
    do begin @(posedge clk_sys_in); t++; end while (wv !== 1'b1 && t < 3000);
  endtask : pulse
  task automatic latch_read(input int w);
    repeat (w) @(posedge clk_sys_in);
    wb(1'b1, `ADCDM_IDX_DC_CONTROL, lctl, 1'b1);
    for (int k = 0; k < 3; k++) begin
      wb(1'b0, `ADCDM_IDX_DC_RESULT_HI + 8'(k), 8'h00, 1'b1);
      res = {res[15:0], q};
    end
  endtask : latch_read
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    v = 8'($urandom(45762));
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    wb(1'b1, 8'h10, 8'h5A, 1'b1);
    for (int k = 0; k < 5; k++) rdc(ri[k], rv[k]);
    for (int k = 0; k < 6; k++) begin
      v = 8'($urandom);
      wb(1'b1, ri[2 + k % 2], v, 1'b1);
      wb(1'b1, ri[2 + k % 2], ~v, 1'b0);
      rdc(ri[2 + k % 2], v);
    end
    wb(1'b1, `ADCDM_IDX_PIN_ONE_FUNC, 8'h28, 1'b1);
    repeat (3) @(posedge clk_sys_in);
    chk("pin enable", 1, oe);
    q = {7'h0, pin};
    t = 0;
    repeat (80) begin
      @(posedge clk_sys_in);
      if (pin && !q[0]) t++;
      q = {7'h0, pin};
    end
    chk("clock rises", 10, t);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, `ADCDM_IDX_OSR, ra[k], 1'b1);
      pulse();
      pulse();
      chk("word spacing", {24'h0, ra[k]} * 32'd8, t);
      chk("right slot", wl, wrt);
    end
    chk("sign high", 0, wl[31]);
    dens <= 8'h00;
    pulse();
    pulse();
    chk("sign low", 1, wl[31]);
    for (int c = 0; c < 4; c++) begin
      dens <= 8'($urandom);
      wb(1'b1, `ADCDM_IDX_SER_CTRL, 8'(c), 1'b1);
      pulse();
      pulse();
      chk("rounded", 0, wl & low_mask(2'(c)));
    end
    dens <= 8'hFF;
    wb(1'b1, `ADCDM_IDX_DC_CONTROL, 8'h00, 1'b1);
    wb(1'b1, `ADCDM_IDX_DC_CONFIG, 8'h82, 1'b1);
    latch_read(200);
    chk("dc average", dc_full(1), res);
    dens <= 8'h00;
    latch_read(200);
    chk("dc held", dc_full(1), res);
    wb(1'b1, `ADCDM_IDX_DC_CONTROL, 8'h00, 1'b1);
    latch_read(200);
    chk("dc relatched", dc_full(0), res);
    wb(1'b1, `ADCDM_IDX_DC_CONTROL, 8'h23, 1'b1);
    lctl = 8'h63;
    latch_read(200);
    lctl = 8'h40;
    chk("dc periodic", dc_full(0), res);
    wb(1'b1, `ADCDM_IDX_DC_CONTROL, 8'h00, 1'b1);
    dens <= 8'hFF;
    wb(1'b1, `ADCDM_IDX_DC_CONFIG, 8'hB4, 1'b1);
    latch_read(400);
    chk("narrow iir", 1, $signed(res) < $signed(24'h380000));
    wb(1'b1, `ADCDM_IDX_DC_CONTROL, 8'h00, 1'b1);
    wb(1'b1, `ADCDM_IDX_DC_CONFIG, 8'hA1, 1'b1);
    latch_read(400);
    chk("wide iir", 1, res >= 24'h380000 && res <= 24'h400000);
    end_of_test();
  end
endmodule : tb_adc_decimation_dc_measure
`default_nettype wire
